// ### verilog/tscfg_defs.vh
// Purpose: command codes, field positions and reset values of the sensor configuration bank
// Assumes: 8-bit registers addressed by SMBus command codes
// Notes:   definitions only
`ifndef TSCFG_DEFS_VH
`define TSCFG_DEFS_VH

// read command codes
`define TSCFG_RD_CFG        8'h03
`define TSCFG_RD_RATE       8'h04
`define TSCFG_RD_LHI        8'h05
`define TSCFG_RD_LLO        8'h06
`define TSCFG_RD_RHI        8'h07
`define TSCFG_RD_RLO        8'h08
`define TSCFG_RD_STATUS     8'h02
// write command codes
`define TSCFG_WR_CFG        8'h09
`define TSCFG_WR_RATE       8'h0A
`define TSCFG_WR_LHI        8'h0B
`define TSCFG_WR_LLO        8'h0C
`define TSCFG_WR_RHI        8'h0D
`define TSCFG_WR_RLO        8'h0E
`define TSCFG_WR_ONESHOT    8'h0F

// configuration field positions
`define TSCFG_CFG_MASK_BIT  7
`define TSCFG_CFG_SD_BIT    6
`define TSCFG_CFG_PIN_BIT   5
`define TSCFG_CFG_RANGE_BIT 2
`define TSCFG_CFG_LEAK_BIT  0
// status field position of the local-high flag
`define TSCFG_STAT_LHI_BIT  6

// reset values
`define TSCFG_RST_CFG       8'h00
`define TSCFG_RST_RATE      8'h08
`define TSCFG_RST_LHI       8'h55
`define TSCFG_RST_LLO       8'h00
`define TSCFG_RST_RHI       8'h55
`define TSCFG_RST_RLO       8'h00
`define TSCFG_RST_BYTE      8'h00

`endif

// ### verilog/tscfg_reg8.v
// Purpose: one 8-bit read/write register with a constant reset value
// Assumes: write strobe and data synchronous to clk_i
// Notes:   reset value is a parameter so each register gets its power-on value
`timescale 1ns/100ps
module tscfg_reg8 #(
    parameter [7:0] RST_VAL = 8'h00
) (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       we_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] q_o
);
    // storage, constant under reset
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST_VAL;
        end else if (we_i) begin
            q_o <= wdata_i;
        end
    end
endmodule // tscfg_reg8

// ### verilog/tscfg_oneshot.v
// Purpose: conversion sequencer: continuous or single conversion from shutdown
// Assumes: conv_done_i pulses once when the converter finishes a conversion
// Notes:   a trigger arriving during a running one-shot is absorbed
`timescale 1ns/100ps
module tscfg_oneshot (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire shutdown_i,
    input  wire trigger_i,
    input  wire conv_done_i,
    output reg  conv_run_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONT = 3'b010;
    localparam [2:0] ST_ONE  = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;

    // next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (!shutdown_i)
                    state_next = ST_CONT;
                else if (trigger_i)
                    state_next = ST_ONE;
            end
            ST_CONT: begin
                // shutdown takes effect between conversions
                if (shutdown_i && conv_done_i)
                    state_next = ST_IDLE;
            end
            ST_ONE: begin
                // exactly one conversion, then back to shutdown, or on to continuous if shutdown was cleared meanwhile
                if (conv_done_i)
                    state_next = shutdown_i ? ST_IDLE : ST_CONT;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // state and registered run output
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg  <= ST_IDLE;
            conv_run_o <= 1'b0;
        end else begin
            state_reg  <= state_next;
            conv_run_o <= state_next[1] | state_next[2];
        end
    end
endmodule // tscfg_oneshot

// ### verilog/tscfg_regs.v
// Purpose: configuration and limit register bank of a local/remote temperature sensor
// Assumes: SMBus byte engine outside delivers command code and data strobes on clk_i
// Notes:   limits drive comparators against the measurement results given on ports
//
// Summary of operation
// - config bit 7 set suppresses the alert output; clear leaves it active
// - config bit 6 set is shutdown; clear gives continuous conversions
// - config bit 5 picks alert (0) or second thermal output (1) on shared pin
// - config bit 2 picks range 0..127 (0) or extended -64..191 (1)
// - config bit 0 enables low bus voltage leakage blocking control; resets zero
// - rate register holds 4-bit rate in bits 3:0, resets 08h, upper bits stored
// - rate read with 04h, written with 0Ah, one storage
// - local high limit, read 05h write 0Bh, resets 55h, compared to local
// - local low limit, read 06h write 0Ch, resets 00h, compared to local
// - remote high limit byte, read 07h write 0Dh, resets 55h, compared
// - remote low limit byte, read 08h write 0Eh, resets 00h, compared
// - config read with 03h, written with 09h, resets 00h
// - local-high flag sets on excess, clears on status read once condition gone
// - write to 0Fh in shutdown runs exactly one conversion then returns
`timescale 1ns/100ps
`include "tscfg_defs.vh"
module tscfg_regs (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] cmd_i,
    input  wire       wr_i,
    input  wire [7:0] wdata_i,
    input  wire       rd_i,
    input  wire [7:0] local_temp_i,
    input  wire [7:0] remote_temp_i,
    input  wire       conv_done_i,
    output reg  [7:0] rdata_o,
    output reg        rvalid_o,
    output reg        alert_out_n_o,
    output reg        thermal_out2_n_o,
    output reg        conv_run_o,
    output reg        range_ext_o,
    output reg        low_bus_voltage_leak_ctl_o,
    output reg  [3:0] conv_rate_sel_o,
    output reg        local_over_flag_o
);
    wire [7:0] device_configuration;
    wire [7:0] conversion_rate;
    wire [7:0] local_upper_threshold;
    wire [7:0] local_lower_threshold;
    wire [7:0] remote_upper_threshold_hi;
    wire [7:0] remote_lower_threshold_hi;
    wire       run_w;
    reg        local_over_flag_reg;
    reg        local_over_flag_next;
    reg  [7:0] rdata_next;
    reg        rhit_next;

    // write decode on write codes only
    wire we_cfg  = wr_i && (cmd_i == `TSCFG_WR_CFG);
    wire we_rate = wr_i && (cmd_i == `TSCFG_WR_RATE);
    wire we_lhi  = wr_i && (cmd_i == `TSCFG_WR_LHI);
    wire we_llo  = wr_i && (cmd_i == `TSCFG_WR_LLO);
    wire we_rhi  = wr_i && (cmd_i == `TSCFG_WR_RHI);
    wire we_rlo  = wr_i && (cmd_i == `TSCFG_WR_RLO);

    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_CFG)) u_cfg (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_cfg),
        .wdata_i (wdata_i),
        .q_o     (device_configuration)
    );
    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_RATE)) u_rate (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_rate),
        .wdata_i (wdata_i),
        .q_o     (conversion_rate)
    );
    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_LHI)) u_lhi (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_lhi),
        .wdata_i (wdata_i),
        .q_o     (local_upper_threshold)
    );
    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_LLO)) u_llo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_llo),
        .wdata_i (wdata_i),
        .q_o     (local_lower_threshold)
    );
    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_RHI)) u_rhi (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_rhi),
        .wdata_i (wdata_i),
        .q_o     (remote_upper_threshold_hi)
    );
    tscfg_reg8 #(.RST_VAL(`TSCFG_RST_RLO)) u_rlo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (we_rlo),
        .wdata_i (wdata_i),
        .q_o     (remote_lower_threshold_hi)
    );

    wire shutdown_ctl            = device_configuration[`TSCFG_CFG_SD_BIT];
    wire alert_out_mask          = device_configuration[`TSCFG_CFG_MASK_BIT];
    wire shared_pin_function_sel = device_configuration[`TSCFG_CFG_PIN_BIT];

    // one-shot trigger only while in shutdown
    tscfg_oneshot u_seq (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .shutdown_i  (shutdown_ctl),
        .trigger_i   (wr_i && (cmd_i == `TSCFG_WR_ONESHOT) && shutdown_ctl),
        .conv_done_i (conv_done_i),
        .conv_run_o  (run_w)
    );

    // limit comparisons, unsigned whole degrees
    wire local_over   = local_temp_i  > local_upper_threshold;
    wire local_under  = local_temp_i  < local_lower_threshold;
    wire remote_over  = remote_temp_i > remote_upper_threshold_hi;
    wire remote_under = remote_temp_i < remote_lower_threshold_hi;
    wire any_limit    = local_over | local_under | remote_over | remote_under;
    wire status_rd    = rd_i && (cmd_i == `TSCFG_RD_STATUS);

    // sticky flag; set wins over the read clear
    always @* begin
        local_over_flag_next = local_over_flag_reg;
        if (conv_done_i && local_over)
            local_over_flag_next = 1'b1;
        else if (status_rd && !local_over)
            local_over_flag_next = 1'b0;
    end

    // read mux answers only read codes
    always @* begin
        rdata_next = `TSCFG_RST_BYTE;
        rhit_next  = 1'b1;
        case (cmd_i)
            `TSCFG_RD_CFG:  rdata_next = device_configuration;
            `TSCFG_RD_RATE: rdata_next = conversion_rate;
            `TSCFG_RD_LHI:  rdata_next = local_upper_threshold;
            `TSCFG_RD_LLO:  rdata_next = local_lower_threshold;
            `TSCFG_RD_RHI:  rdata_next = remote_upper_threshold_hi;
            `TSCFG_RD_RLO:  rdata_next = remote_lower_threshold_hi;
            `TSCFG_RD_STATUS: begin
                rdata_next = `TSCFG_RST_BYTE;
                rdata_next[`TSCFG_STAT_LHI_BIT] = local_over_flag_reg;
            end
            default: rhit_next = 1'b0; // write-only or unknown code reads zero
        endcase
    end

    // registered outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            local_over_flag_reg        <= 1'b0;
            rdata_o                    <= `TSCFG_RST_BYTE;
            rvalid_o                   <= 1'b0;
            alert_out_n_o              <= 1'b1;
            thermal_out2_n_o           <= 1'b1;
            conv_run_o                 <= 1'b0;
            range_ext_o                <= 1'b0;
            low_bus_voltage_leak_ctl_o <= 1'b0;
            conv_rate_sel_o            <= 4'h8;
            local_over_flag_o          <= 1'b0;
        end else begin
            local_over_flag_reg <= local_over_flag_next;
            local_over_flag_o   <= local_over_flag_next;
            rvalid_o            <= rd_i;
            if (rd_i)
                rdata_o <= rhit_next ? rdata_next : `TSCFG_RST_BYTE;
            alert_out_n_o    <= ~(!shared_pin_function_sel && !alert_out_mask && local_over_flag_next);
            thermal_out2_n_o <= ~(shared_pin_function_sel && any_limit);
            conv_run_o <= run_w;
            range_ext_o <= device_configuration[`TSCFG_CFG_RANGE_BIT];
            low_bus_voltage_leak_ctl_o <= device_configuration[`TSCFG_CFG_LEAK_BIT];
            // low nibble is the rate select
            conv_rate_sel_o <= conversion_rate[3:0];
        end
    end
endmodule // tscfg_regs

// ### bench/tscfg_asserts.sv
// Purpose: port checks on the configuration register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   registered copies checked inside short windows
`timescale 1ns/100ps
module tscfg_asserts (
    input wire       clk_i,
    input wire       rst_n_i,
    input wire [7:0] cmd_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire       conv_done_i,
    input wire       rvalid_o,
    input wire [7:0] rdata_o,
    input wire       alert_out_n_o,
    input wire       conv_run_o,
    input wire       range_ext_o,
    input wire       low_bus_voltage_leak_ctl_o,
    input wire [3:0] conv_rate_sel_o,
    input wire       local_over_flag_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // strobes per code; a run may also start after reset
    wire cfg_w  = wr_i & (cmd_i == 8'h09);
    wire rate_w = wr_i & (cmd_i == 8'h0A);
    wire kick   = wr_i | ~rst_n_i;
    property p_rd_ans; rd_i |=> rvalid_o; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rv_cause; rvalid_o |-> $past(rd_i); endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
    property p_rdata_hold; !rvalid_o |-> $stable(rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_range_chg; $changed(range_ext_o) |-> $past(cfg_w) || $past(cfg_w, 2); endproperty
    a_range_chg: assert property (p_range_chg) else $error("range moved unwritten");
    property p_leak_chg; $changed(low_bus_voltage_leak_ctl_o) |-> $past(cfg_w) || $past(cfg_w, 2); endproperty
    a_leak_chg: assert property (p_leak_chg) else $error("leak control moved unwritten");
    property p_rate_chg; $changed(conv_rate_sel_o) |-> $past(rate_w) || $past(rate_w, 2); endproperty
    a_rate_chg: assert property (p_rate_chg) else $error("rate moved unwritten");
    property p_flag_rise; $rose(local_over_flag_o) |-> $past(conv_done_i) || $past(conv_done_i, 2); endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without conversion");
    property p_alert; $fell(alert_out_n_o) |-> ##[0:1] local_over_flag_o; endproperty
    a_alert: assert property (p_alert) else $error("alert without flag");
    property p_run_rise; $rose(conv_run_o) |-> $past(kick) || $past(kick, 2) || $past(kick, 3); endproperty
    a_run_rise: assert property (p_run_rise) else $error("run started unasked");
    property p_run_fall;
        $fell(conv_run_o) |-> $past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3);
    endproperty
    a_run_fall: assert property (p_run_fall) else $error("run stopped mid conversion");
    c_read: cover property (rd_i ##1 rvalid_o);
    c_flag: cover property ($rose(local_over_flag_o));
    c_stop: cover property ($fell(conv_run_o));
endmodule // tscfg_asserts
bind tscfg_regs tscfg_asserts i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .wr_i(wr_i),
    .rd_i(rd_i), .conv_done_i(conv_done_i), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
    .alert_out_n_o(alert_out_n_o), .conv_run_o(conv_run_o), .range_ext_o(range_ext_o),
    .low_bus_voltage_leak_ctl_o(low_bus_voltage_leak_ctl_o), .conv_rate_sel_o(conv_rate_sel_o),
    .local_over_flag_o(local_over_flag_o));

// ### bench/tscfg_conv_model.sv
// Purpose: converter stand-in answering run requests with done pulses
// Assumes: run level from the bank, one clock
// Notes:   fixed eight-cycle conversion; counter clears when idle
`timescale 1ns/100ps
module tscfg_conv_model (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire run_i,
    output wire done_o
);
    reg [2:0] cnt_reg;
    // idle clears the count so a new run always takes the full time
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            cnt_reg <= 3'h0;
        else if (run_i)
            cnt_reg <= cnt_reg + 3'h1;
        else
            cnt_reg <= 3'h0;
    end
    assign done_o = run_i & (cnt_reg == 3'h7);
endmodule // tscfg_conv_model

// ### bench/tb.sv
// Purpose: register bank tests through the command-code strobes
// Assumes: inputs driven at the falling edge
// Notes:   converter model closes the run loop
`timescale 1ns/100ps
module tb;
    localparam [47:0] RV = 48'h00_08_55_00_55_00;
    localparam [47:0] WV = 48'h1A_F3_40_21_66_12;
    reg        clk_i = 1'h0;
    reg        rst_n_i = 1'h0;
    reg  [7:0] cmd_i = 8'h00, wdata_i = 8'h00, local_temp_i = 8'h60, remote_temp_i = 8'h20;
    reg        wr_i = 1'h0, rd_i = 1'h0;
    wire       conv_done_i, rvalid_o, alert_n, therm_n, conv_run_o, range_o, leak_o, flag_o;
    wire [7:0] rdata_o;
    wire [3:0] rate_o;
    integer    err_count = 0, comparisons = 0, cyc = 0, ndone = 0, i;
    always #10 clk_i = ~clk_i;
    tscfg_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .wr_i(wr_i), .wdata_i(wdata_i),
        .rd_i(rd_i), .local_temp_i(local_temp_i), .remote_temp_i(remote_temp_i), .conv_done_i(conv_done_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .alert_out_n_o(alert_n), .thermal_out2_n_o(therm_n),
        .conv_run_o(conv_run_o), .range_ext_o(range_o), .low_bus_voltage_leak_ctl_o(leak_o),
        .conv_rate_sel_o(rate_o), .local_over_flag_o(flag_o));
    tscfg_conv_model i_conv (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(conv_run_o), .done_o(conv_done_i));
    // completed conversions and hang guard
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (conv_done_i === 1'h1)
            ndone = ndone + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    task chk(input [7:0] s, input [7:0] e);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
            end
        end
    endtask
    task wr(input [7:0] c, input [7:0] d);
        begin
            @(negedge clk_i);
            cmd_i = c;
            wdata_i = d;
            wr_i = 1'h1;
            @(negedge clk_i);
            wr_i = 1'h0;
            repeat (3) @(negedge clk_i);
        end
    endtask
    // read strobe, answer one cycle later
    task rc(input [7:0] c, input [7:0] e);
        begin
            @(negedge clk_i);
            cmd_i = c;
            rd_i = 1'h1;
            @(negedge clk_i);
            rd_i = 1'h0;
            chk({7'h00, rvalid_o}, 8'h01);
            chk(rdata_o, e);
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'h1;
        for (i = 0; i < 6; i = i + 1)
            rc(8'h03 + i[7:0], RV[47-8*i -: 8]);
        chk({rate_o, 2'h0, range_o, leak_o}, 8'h80);
        $display("test reset values done");
        repeat (20) @(negedge clk_i);
        chk({7'h00, flag_o}, 8'h01);
        chk({7'h00, alert_n}, 8'h00);
        wr(8'h09, 8'h80);
        chk({7'h00, alert_n}, 8'h01);
        wr(8'h09, 8'h20);
        chk({6'h00, alert_n, therm_n}, 8'h02);
        local_temp_i = 8'h10;
        rc(8'h02, 8'h40);
        rc(8'h02, 8'h00);
        $display("test limit flag done");
        for (i = 0; i < 6; i = i + 1)
            wr(8'h09 + i[7:0], WV[47-8*i -: 8]);
        for (i = 0; i < 6; i = i + 1)
            rc(8'h03 + i[7:0], WV[47-8*i -: 8]);
        chk({4'h0, rate_o}, 8'h03);
        wr(8'h05, 8'hAA);
        rc(8'h0B, 8'h00);
        rc(8'h05, 8'h40);
        wr(8'h09, 8'h05);
        chk({6'h00, range_o, leak_o}, 8'h03);
        $display("test register access done");
        wr(8'h09, 8'h40);
        for (i = 0; i < 40 && conv_run_o !== 1'h0; i = i + 1)
            @(negedge clk_i);
        ndone = 0;
        repeat (20) @(negedge clk_i);
        chk(ndone[7:0], 8'h00);
        wr(8'h0F, 8'h00);
        repeat (40) @(negedge clk_i);
        chk(ndone[7:0], 8'h01);
        chk({7'h00, conv_run_o}, 8'h00);
        $display("test one-shot done");
        // shared pin as thermal output: remote high, remote low and local low compares each trip it on their own
        wr(8'h09, 8'h20);
        local_temp_i = 8'h30;
        remote_temp_i = 8'h70;
        repeat (2) @(negedge clk_i);
        chk({7'h00, therm_n}, 8'h00);
        remote_temp_i = 8'h08;
        repeat (2) @(negedge clk_i);
        chk({7'h00, therm_n}, 8'h00);
        remote_temp_i = 8'h20;
        repeat (2) @(negedge clk_i);
        chk({7'h00, therm_n}, 8'h01);
        local_temp_i = 8'h18;
        repeat (2) @(negedge clk_i);
        chk({7'h00, therm_n}, 8'h00);
        $display("test limit compare done");
        end_sim;
    end
endmodule // tb
